// ### tpc_pkg.sv
package tpc_pkg;
    // Register index as printed; byte address is four times the index
    localparam logic [11:0] TPC_CSR_IDX = 12'h123;
    localparam logic [11:0] TPC_SWAP_IDX = 12'h121;
    localparam logic [13:0] TPC_CSR_ADDR = 14'(TPC_CSR_IDX * 4);
    localparam logic [13:0] TPC_SWAP_ADDR = 14'(TPC_SWAP_IDX * 4);
    localparam int TPC_ADDR_W = 14;
    // Field positions of the control/status register and the swap register
    localparam int TPC_BIT_TYPE = 7;
    localparam int TPC_BIT_INJ = 6;
    localparam int TPC_BIT_INV = 5;
    localparam int TPC_BIT_LOCK = 4;
    localparam int TPC_BIT_CHK = 3;
    localparam int TPC_BIT_GEN = 2;
    localparam int TPC_BIT_RXBYP = 1;
    localparam int TPC_BIT_TXBYP = 0;
    localparam int TPC_BIT_SWAP = 3;
    // Reset values
    localparam logic [7:0] TPC_CSR_RST = 8'h00;
    localparam logic [14:0] TPC_LFSR_SEED = 15'h7fff;
    // Lock acquisition and loss thresholds, in bits
    localparam logic [5:0] TPC_LOCK_RUN = 6'h20;
    localparam logic [3:0] TPC_LOSS_ERRS = 4'h6;
    localparam logic [5:0] TPC_LOSS_WIN = 6'h3f;
    // Quasi-random signal forces a one after this many zeros
    localparam logic [3:0] TPC_QRSS_ZMAX = 4'he;
    localparam int TPC_FIFO_W = 1;
    localparam int TPC_FIFO_D = 16;
    typedef enum logic [1:0] {
        TPC_HUNT = 2'b00,
        TPC_VERIFY = 2'b01,
        TPC_LOCKED = 2'b10
    } tpc_chk_state_t;
endpackage : tpc_pkg

// ### tpc_fifo.sv
module tpc_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic out_valid_reg;
    wire logic [AW:0] count = wr_ptr_reg - rd_ptr_reg;
    wire logic full = (count == (AW+1)'(DEPTH));
    wire logic empty = (count == '0);
    // Output register refills when empty or being drained
    wire logic load = !empty && (!out_valid_reg || out_ready_i);
    wire logic push = in_valid_i && !full;

    assign in_ready_o = !full;
    assign out_data_o = out_data_reg;
    assign out_valid_o = out_valid_reg;

    // Storage array without reset, data only
    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers and registered read port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (ce_i) begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (load) begin
                out_data_reg <= mem_reg[rd_ptr_reg[AW-1:0]];
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
                out_valid_reg <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_reg <= 1'b0;
            end
        end
    end
endmodule : tpc_fifo

// ### tpc_ctrl.sv
// Function
// R1 - Bit 4 reads 1 while checker is locked, 0 otherwise, read only.
// R2 - Swap bit 3 of second register picks line or backplane direction.
// R3 - Check enabled, swap off: receive side checks line data, locks on match.
// R4 - Check enabled, swap on: transmit side checks transmit backplane data.
// R5 - Generate enabled, swap off: transmit side sends pattern toward line.
// R6 - Generate enabled, swap on: receive side sends pattern to receive backplane.
// R7 - Clearing enables stops functions; both enables reset to zero.
// R8 - Bit 1 set bypasses receive framing; reset clear.
// R9 - Bit 0 set bypasses transmit framing; reset clear.
// R10 - Type bit: 0 gives x^15+x^14+1 sequence, 1 gives quasi-random.
// R11 - Each rising edge of inject inverts one generated bit, only when generating.
// R12 - Lock after run of matches, drop after too many errors, automatically.
//
// Our own choice: the Wishbone slave port.
module tpc_ctrl
    import tpc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [tpc_pkg::TPC_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial data, one bit per strobe
    input wire logic bit_tick_i,
    input wire logic line_rx_bit_i,
    input wire logic tx_bp_bit_i,
    input wire logic tx_norm_bit_i,
    input wire logic rx_norm_bit_i,
    output logic line_tx_bit_o,
    output logic rx_bp_bit_o,
    output logic tx_bp_ready_o,
    output logic rx_framing_bypass_o,
    output logic tx_framing_bypass_o,
    output logic pattern_lock_flag_o
);
    import tpc_pkg::*;

    // One step of the 15-stage generator, shift left, new bit at lsb
    function automatic logic [14:0] lfsr_step(input logic [14:0] s);
        return {s[13:0], s[14] ^ s[13]};
    endfunction : lfsr_step

    // Quasi-random output: suppress runs longer than the zero limit
    function automatic logic qrss_bit(input logic raw, input logic [3:0] zeros);
        return (zeros >= TPC_QRSS_ZMAX) ? 1'b1 : raw;
    endfunction : qrss_bit

    logic [7:0] csr_reg;
    logic swap_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic inj_prev_reg;
    logic inj_pend_reg;
    logic [14:0] gen_lfsr_reg;
    logic [3:0] gen_zeros_reg;
    logic gen_out_reg;
    logic [14:0] chk_lfsr_reg;
    logic [3:0] chk_zeros_reg;
    logic [5:0] run_reg;
    logic [3:0] err_reg;
    logic [5:0] win_reg;
    tpc_chk_state_t state_reg;
    tpc_chk_state_t state_next;
    logic line_rx_s1_reg;
    logic line_rx_s2_reg;
    logic line_tx_reg;
    logic rx_bp_reg;

    // Register decode
    wire logic wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
    wire logic hit_csr = (wb_adr_i == TPC_CSR_ADDR);
    wire logic hit_swap = (wb_adr_i == TPC_SWAP_ADDR);
    wire logic wr_csr = wb_req && wb_we_i && hit_csr && wb_sel_i[0];
    wire logic wr_swap = wb_req && wb_we_i && hit_swap && wb_sel_i[0];
    wire logic swap = swap_reg; // R2
    wire logic gen_en = csr_reg[TPC_BIT_GEN];
    wire logic chk_en = csr_reg[TPC_BIT_CHK];
    wire logic type_q = csr_reg[TPC_BIT_TYPE];
    wire logic inv = csr_reg[TPC_BIT_INV];
    wire logic lock = (state_reg == TPC_LOCKED);
    wire logic [7:0] csr_view = {csr_reg[7:5], lock, csr_reg[3:0]}; // R1

    // Checked stream: backplane bits go through the FIFO when swapped
    wire logic fifo_data;
    wire logic fifo_valid;
    wire logic fifo_in_ready;
    wire logic chk_src_bit = swap ? fifo_data : line_rx_s2_reg; // R3 R4
    wire logic chk_strobe = bit_tick_i && (swap ? fifo_valid : 1'b1);
    wire logic chk_bit = chk_src_bit ^ inv;
    wire logic chk_go = ce_i && chk_en && chk_strobe; // R7

    // Generator output bit with single inversion for injection
    wire logic gen_raw = gen_lfsr_reg[14];
    wire logic gen_pat = type_q ? qrss_bit(gen_raw, gen_zeros_reg) : gen_raw; // R10
    wire logic gen_bit = gen_pat ^ inj_pend_reg ^ inv; // R11
    wire logic gen_go = ce_i && gen_en && bit_tick_i;

    // Expected bit predicted from the last 15 bits held in the reference
    wire logic chk_raw = chk_lfsr_reg[14] ^ chk_lfsr_reg[13];
    wire logic chk_exp = type_q ? qrss_bit(chk_raw, chk_zeros_reg) : chk_raw; // R10
    wire logic match = (chk_bit == chk_exp);
    // Forced ones hide the raw bit, and a locked checker must not absorb bit errors
    wire logic chk_fill = (lock || (type_q && chk_zeros_reg >= TPC_QRSS_ZMAX)) ? chk_raw : chk_bit;

    tpc_fifo #(
        .WIDTH(TPC_FIFO_W),
        .DEPTH(TPC_FIFO_D)
    ) u_bp_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_data_i(tx_bp_bit_i),
        .in_valid_i(bit_tick_i && swap && chk_en),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(bit_tick_i && chk_en)
    );
    // Backplane source must pause when the checker falls behind
    assign tx_bp_ready_o = fifo_in_ready;

    // Bus slave: single-cycle answer, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end else if (ce_i) begin
            ack_reg <= wb_req;
            if (wb_req && !wb_we_i) begin
                rdata_reg <= hit_csr ? {24'h000000, csr_view} :
                             hit_swap ? {28'h0000000, swap_reg, 3'h0} : 32'h00000000;
            end
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Control bits; lock bit is never written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            csr_reg <= TPC_CSR_RST; // R7 R8 R9
            swap_reg <= 1'b0;
        end else if (ce_i) begin
            if (wr_csr) begin
                csr_reg <= {wb_dat_i[7:5], 1'b0, wb_dat_i[3:0]};
            end
            if (wr_swap) begin
                swap_reg <= wb_dat_i[TPC_BIT_SWAP];
            end
        end
    end

    // Error inject edge catch; pending until next generated bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inj_prev_reg <= 1'b0;
            inj_pend_reg <= 1'b0;
        end else if (ce_i) begin
            inj_prev_reg <= csr_reg[TPC_BIT_INJ];
            if (csr_reg[TPC_BIT_INJ] && !inj_prev_reg && gen_en) begin
                inj_pend_reg <= 1'b1; // R11
            end else if (gen_go || !gen_en) begin
                inj_pend_reg <= 1'b0; // R11
            end
        end
    end

    // Pattern generator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_lfsr_reg <= TPC_LFSR_SEED;
            gen_zeros_reg <= '0;
            gen_out_reg <= 1'b0;
        end else if (gen_go) begin
            gen_lfsr_reg <= lfsr_step(gen_lfsr_reg); // R5 R6
            gen_zeros_reg <= gen_pat ? 4'h0 : gen_zeros_reg + 4'h1;
            gen_out_reg <= gen_bit;
        end
    end

    // Line input synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_rx_s1_reg <= 1'b0;
            line_rx_s2_reg <= 1'b0;
        end else if (ce_i) begin
            line_rx_s1_reg <= line_rx_bit_i;
            line_rx_s2_reg <= line_rx_s1_reg;
        end
    end

    // Checker state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TPC_HUNT: state_next = TPC_VERIFY;
            TPC_VERIFY: begin
                if (!match) begin
                    state_next = TPC_HUNT;
                end else if (run_reg == TPC_LOCK_RUN - 6'h01) begin
                    state_next = TPC_LOCKED; // R12
                end
            end
            TPC_LOCKED: begin
                if (!match && err_reg == TPC_LOSS_ERRS - 4'h1) begin
                    state_next = TPC_HUNT; // R12
                end
            end
            default: state_next = TPC_HUNT;
        endcase
    end

    // Checker registers; hunting seeds the reference from received bits
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && !chk_en)) begin
            state_reg <= TPC_HUNT; // R7
            chk_lfsr_reg <= TPC_LFSR_SEED;
            chk_zeros_reg <= '0;
            run_reg <= '0;
            err_reg <= '0;
            win_reg <= '0;
        end else if (chk_go) begin
            state_reg <= state_next; // R3 R4
            chk_lfsr_reg <= {chk_lfsr_reg[13:0], chk_fill};
            chk_zeros_reg <= chk_bit ? 4'h0 : chk_zeros_reg + 4'h1;
            run_reg <= (state_reg == TPC_VERIFY && match) ? run_reg + 6'h01 : 6'h00;
            win_reg <= (state_reg == TPC_LOCKED) ? win_reg + 6'h01 : 6'h00;
            if (state_reg != TPC_LOCKED || win_reg == TPC_LOSS_WIN) begin
                err_reg <= '0;
            end else if (!match) begin
                err_reg <= err_reg + 4'h1;
            end
        end
    end

    // Output muxing of generated pattern versus normal traffic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_tx_reg <= 1'b0;
            rx_bp_reg <= 1'b0;
        end else if (ce_i) begin
            line_tx_reg <= (gen_en && !swap) ? gen_out_reg : tx_norm_bit_i; // R5
            rx_bp_reg <= (gen_en && swap) ? gen_out_reg : rx_norm_bit_i; // R6
        end
    end
    assign line_tx_bit_o = line_tx_reg;
    assign rx_bp_bit_o = rx_bp_reg;
    assign rx_framing_bypass_o = csr_reg[TPC_BIT_RXBYP]; // R8
    assign tx_framing_bypass_o = csr_reg[TPC_BIT_TXBYP]; // R9
    assign pattern_lock_flag_o = lock; // R1

    a_lock_read_view: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        (ack_reg && $past(wb_req && !wb_we_i && hit_csr && ce_i))
            |-> (rdata_reg[TPC_BIT_LOCK] == $past(lock)))
        else $error("lock bit read mismatch");
    a_swap_write: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (wr_swap && ce_i) |=> (swap_reg == $past(wb_dat_i[TPC_BIT_SWAP])))
        else $error("swap bit not stored");
    a_lock_needs_en: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        lock |-> $past(chk_en))
        else $error("lock without checker enable");
    a_fifo_feeds_chk: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        (swap && chk_go) |-> (chk_src_bit == fifo_data))
        else $error("checker source wrong");
    a_line_gen_out: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        (ce_i && gen_en && !swap) |=> (line_tx_reg == $past(gen_out_reg)))
        else $error("line output not pattern");
    a_bp_gen_out: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        (ce_i && gen_en && swap) |=> (rx_bp_reg == $past(gen_out_reg)))
        else $error("backplane output not pattern");
    a_chk_off_unlock: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (ce_i && !chk_en) |=> !lock)
        else $error("lock kept with checker off");
    a_bypass_bits: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        (wr_csr && ce_i) |=> (rx_framing_bypass_o == $past(wb_dat_i[TPC_BIT_RXBYP])))
        else $error("rx bypass not following write");
    a_tx_bypass: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        (wr_csr && ce_i) |=> (tx_framing_bypass_o == $past(wb_dat_i[TPC_BIT_TXBYP])))
        else $error("tx bypass not following write");
    a_inject_once: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        (inj_pend_reg && gen_go) |=> !inj_pend_reg)
        else $error("inject held past one bit");
    a_lock_after_run: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        $rose(lock) |-> $past(run_reg == TPC_LOCK_RUN - 6'h01))
        else $error("lock without full match run");
endmodule : tpc_ctrl

// ### tpc_far_model.sv
// Far side stand-in: line plug and backplane wrap with a bit clock strobe
module tpc_far_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic corrupt_i,
    input wire logic line_tx_bit_i,
    input wire logic rx_bp_bit_i,
    output logic bit_tick_o,
    output logic line_rx_bit_o,
    output logic tx_bp_bit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] tick_cnt_reg;
    logic [1:0] tick_cnt_next;

    // Strobe every cycle, or one in three when slowed
    assign tick_cnt_next = (tick_cnt_reg == (slow_i ? 2'h2 : 2'h0)) ? 2'h0 : tick_cnt_reg + 2'h1;
    assign bit_tick_o = !rst_i && (tick_cnt_reg == 2'h0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_reg <= 2'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // Wrapped data; corruption inverts every bit so a checker cannot relock on it
    assign line_rx_bit_o = line_tx_bit_i ^ corrupt_i;
    assign tx_bp_bit_o = rx_bp_bit_i ^ corrupt_i;
endmodule : tpc_far_model

// ### testbench.sv
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h expected %h", $time, (g), (e)); end end

module testbench;
    import tpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [TPC_ADDR_W-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic bit_tick_i, line_rx_bit_i, tx_bp_bit_i, line_tx_bit_o, rx_bp_bit_o, tx_bp_ready_o;
    logic tx_norm_bit_i = 1'b0;
    logic rx_norm_bit_i = 1'b0;
    logic rx_framing_bypass_o, tx_framing_bypass_o, pattern_lock_flag_o;
    logic slow = 1'b0;
    logic corrupt = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] exp_w;
    int compares = 0;
    int miscompares = 0;
    int cycles = 0;
    int unsigned seed_v;

    tpc_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .bit_tick_i(bit_tick_i), .line_rx_bit_i(line_rx_bit_i), .tx_bp_bit_i(tx_bp_bit_i),
        .tx_norm_bit_i(tx_norm_bit_i), .rx_norm_bit_i(rx_norm_bit_i), .line_tx_bit_o(line_tx_bit_o),
        .rx_bp_bit_o(rx_bp_bit_o), .tx_bp_ready_o(tx_bp_ready_o), .rx_framing_bypass_o(rx_framing_bypass_o),
        .tx_framing_bypass_o(tx_framing_bypass_o), .pattern_lock_flag_o(pattern_lock_flag_o));

    tpc_far_model far_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .corrupt_i(corrupt),
        .line_tx_bit_i(line_tx_bit_o), .rx_bp_bit_i(rx_bp_bit_o), .bit_tick_o(bit_tick_i),
        .line_rx_bit_o(line_rx_bit_i), .tx_bp_bit_o(tx_bp_bit_i));

    // 200 MHz
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // Classic single cycle; read expectations are queued before the request
    task automatic wb_cycle(input logic we, input logic [13:0] adr, input logic [7:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= {24'h0, dat};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_cycle

    task automatic rd(input logic [13:0] adr, input logic [7:0] exp);
        exp_q.push_back({24'h0, exp});
        wb_cycle(1'b0, adr, 8'h00);
    endtask : rd

    // With generation off the normal traffic passes with one cycle of delay
    task automatic norm_check();
        logic [1:0] v;
        repeat (8) begin
            v = 2'($urandom);
            @(posedge clk_i);
            tx_norm_bit_i <= v[0];
            rx_norm_bit_i <= v[1];
            @(posedge clk_i);
            #1;
            `CHK(line_tx_bit_o, v[0])
            `CHK(rx_bp_bit_o, v[1])
        end
    endtask : norm_check

    // Read data is judged at the acknowledging edge against the oldest note
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
            exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hffff_ffff;
            `CHK(wb_dat_o, exp_w)
        end
    end

    // Hang guard, well above the expected run of some 4400 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 12000) begin
            miscompares++;
            $display("[FAIL] %0t timeout", $time);
            conclude();
        end
    end

    initial begin
        seed_v = $urandom(11363);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        `CHK(pattern_lock_flag_o, 1'b0)
        rd(TPC_CSR_ADDR, TPC_CSR_RST);
        rd(TPC_SWAP_ADDR, 8'h00);
        rd(14'h0100, 8'h00);
        wb_cycle(1'b1, TPC_CSR_ADDR, 8'h13);
        rd(TPC_CSR_ADDR, 8'h03);
        `CHK({rx_framing_bypass_o, tx_framing_bypass_o}, 2'b11)
        wb_cycle(1'b1, TPC_CSR_ADDR, 8'h01);
        `CHK({rx_framing_bypass_o, tx_framing_bypass_o}, 2'b01)
        wb_cycle(1'b1, TPC_CSR_ADDR, 8'h00);
        `CHK({rx_framing_bypass_o, tx_framing_bypass_o}, 2'b00)
        wb_cycle(1'b1, 14'h0100, 8'hff);
        rd(TPC_CSR_ADDR, 8'h00);
        norm_check();
        `CHK(tx_bp_ready_o, 1'b1)
        // Clock enable low must freeze the line output
        @(posedge clk_i);
        ce_i <= 1'b0;
        tx_norm_bit_i <= ~tx_norm_bit_i;
        repeat (3) @(posedge clk_i);
        `CHK(line_tx_bit_o, !tx_norm_bit_i)
        ce_i <= 1'b1;
        // Every type in both directions: lock on wrapped data, lose it on corruption
        for (int t = 0; t < 2; t++) begin
            for (int s = 0; s < 2; s++) begin
                slow <= 1'($urandom);
                wb_cycle(1'b1, TPC_SWAP_ADDR, 8'(s << 3));
                rd(TPC_SWAP_ADDR, 8'(s << 3));
                wb_cycle(1'b1, TPC_CSR_ADDR, 8'(t << 7) | 8'h0c);
                repeat (600) @(posedge clk_i);
                rd(TPC_CSR_ADDR, 8'(t << 7) | 8'h1c);
                if (t == 0 && s == 0) begin
                    wb_cycle(1'b1, TPC_CSR_ADDR, 8'h4c);
                    repeat (200) @(posedge clk_i);
                    rd(TPC_CSR_ADDR, 8'h5c);
                end
                corrupt <= 1'b1;
                repeat (300) @(posedge clk_i);
                rd(TPC_CSR_ADDR, 8'(t << 7) | 8'h0c | ((t == 0 && s == 0) ? 8'h40 : 8'h00));
                corrupt <= 1'b0;
                wb_cycle(1'b1, TPC_CSR_ADDR, 8'h00);
                repeat (100) @(posedge clk_i);
                `CHK(pattern_lock_flag_o, 1'b0)
            end
        end
        wb_cycle(1'b1, TPC_SWAP_ADDR, 8'h00);
        norm_check();
        rd(TPC_CSR_ADDR, 8'h00);
        repeat (4) @(posedge clk_i);
        `CHK(exp_q.size(), 0)
        conclude();
    end
endmodule : testbench
